// [plp_encoder_top.sv]
/*
 * Top of the pin-level PWM encoder: Avalon-MM register slave,
 * pair selection, pin drive and readback.
 * Assumes the Avalon master holds its request while waitrequest is high
 * and that the pin input is asynchronous to clk.
 */
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Two-bit selector picks a 16, 64, 256 or 1024 cycle time unit.
// - The same time unit drives the pin output and the encoder.
// - One cycle lasts high count plus low count time units.
// - High phase lasts the high count times the time unit.
// - Low phase lasts the low count times the time unit.
// - Zero high count makes that logic state a steady low.
// - Zero low count alone makes that logic state a steady high.
// - Both counts zero gives steady low, over the steady high case.
// - Logic-low state has its own pair, reset high 0, low all ones.
// - Logic-high state has its own pair, reset to 0x3F80.
// - Scratch word at 0x59 resets to 0x5555 and does nothing.
// - Scratch word stays readable so the CRC check can cover it.
// - Read/write CRC word at 0x7E resets to zero.
module plp_encoder_top
    import plp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic io_pin_b_in,
    output logic io_pin_b_out,
    output logic io_pin_b_oe
);

    // ****************************************
    // Declarations
    // ****************************************

    logic [15:0] low_cfg_reg, low_cfg_next;
    logic [13:0] high_cfg_reg, high_cfg_next;
    logic [15:0] scratch_reg, scratch_next;
    logic [15:0] crc_reg, crc_next;
    logic [1:0] ctrl_reg, ctrl_next;

    logic ack_reg, ack_next;
    logic [15:0] rdata_reg, rdata_next;

    logic sync1_reg, sync1_next;
    logic sync2_reg, sync2_next;

    logic [7:0] idx;
    logic req;
    logic wr_go;
    logic [1:0] pin_b_time_base_sel;
    logic [6:0] low_state_high_count;
    logic [6:0] low_state_low_count;
    logic [6:0] high_state_high_count;
    logic [6:0] high_state_low_count;
    logic [15:0] status_word;
    logic [15:0] high_merge;

    plp_pwm_if pwm_bus();

    // ****************************************
    // Bus handshake
    // ****************************************

    // Word index from the byte address
    assign idx = avs_address[9:2];
    assign req = avs_read || avs_write;

    // One wait cycle, then the answer
    assign avs_waitrequest = req && !ack_reg;
    assign wr_go = avs_write && ack_reg;

    always_comb begin
        ack_next = req && !ack_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    // ****************************************
    // Register file
    // ****************************************

    // Merged high word; reserved top bits fall away
    assign high_merge = plp_merge16({2'h0, high_cfg_reg}, avs_writedata,
        avs_byteenable);

    // Next values of the software registers
    always_comb begin
        low_cfg_next = low_cfg_reg;
        high_cfg_next = high_cfg_reg;
        scratch_next = scratch_reg;
        crc_next = crc_reg;
        ctrl_next = ctrl_reg;
        if (wr_go) begin
            unique case (idx)
                IDX_LOW_CFG: begin
                    low_cfg_next = plp_merge16(low_cfg_reg, avs_writedata,
                        avs_byteenable);
                end
                IDX_HIGH_CFG: begin
                    high_cfg_next = high_merge[13:0];
                end
                IDX_SCRATCH: begin
                    scratch_next = plp_merge16(scratch_reg, avs_writedata,
                        avs_byteenable);
                end
                IDX_CRC: begin
                    crc_next = plp_merge16(crc_reg, avs_writedata,
                        avs_byteenable);
                end
                IDX_CTRL: begin
                    if (avs_byteenable[0]) begin
                        ctrl_next = avs_writedata[1:0];
                    end
                end
                default: begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
    end

    // Software registers and their reset values
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cfg_reg <= RST_LOW_CFG;
            high_cfg_reg <= RST_HIGH_CFG[13:0];
            scratch_reg <= RST_SCRATCH;
            crc_reg <= RST_CRC;
            ctrl_reg <= RST_CTRL;
        end else begin
            low_cfg_reg <= low_cfg_next;
            high_cfg_reg <= high_cfg_next;
            scratch_reg <= scratch_next;
            crc_reg <= crc_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************
    // Read path
    // ****************************************

    // Live state seen by software
    assign status_word = {12'h000, pwm_bus.in_high, sync2_reg,
        ctrl_reg[CTRL_STATE], pwm_bus.level};

    // Read mux, unmapped reads give zero
    always_comb begin
        rdata_next = rdata_reg;
        if (avs_read && !ack_reg) begin
            unique case (idx)
                IDX_LOW_CFG: rdata_next = low_cfg_reg;
                IDX_HIGH_CFG: rdata_next = {2'h0, high_cfg_reg};
                IDX_SCRATCH: rdata_next = scratch_reg;
                IDX_CRC: rdata_next = crc_reg;
                IDX_CTRL: rdata_next = {14'h0000, ctrl_reg};
                IDX_STATUS: rdata_next = status_word;
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign avs_readdata = {16'h0000, rdata_reg};

    // ****************************************
    // Field split
    // ****************************************

    // Named fields of the two pairs
    assign pin_b_time_base_sel = low_cfg_reg[TB_MSB:TB_LSB];
    assign low_state_high_count = low_cfg_reg[HC_MSB:HC_LSB];
    assign low_state_low_count = low_cfg_reg[LC_MSB:LC_LSB];
    assign high_state_high_count = high_cfg_reg[HC_MSB:HC_LSB];
    assign high_state_low_count = high_cfg_reg[LC_MSB:LC_LSB];

    // Pair for the logic state now requested
    assign pwm_bus.high_cnt = ctrl_reg[CTRL_STATE] ?
        high_state_high_count : low_state_high_count;
    assign pwm_bus.low_cnt = ctrl_reg[CTRL_STATE] ?
        high_state_low_count : low_state_low_count;

    // ****************************************
    // PWM engine
    // ****************************************

    // One time base serves output and encoder alike
    plp_time_base u_time_base (
        .clk(clk),
        .sys_rst(sys_rst),
        .tb_sel(pin_b_time_base_sel),
        .pwm(pwm_bus.src)
    );

    plp_phase_gen u_phase_gen (
        .clk(clk),
        .sys_rst(sys_rst),
        .pwm(pwm_bus.gen)
    );

    // ****************************************
    // Pin
    // ****************************************

    // Encoded level drives the pin when enabled
    assign io_pin_b_out = pwm_bus.level;
    assign io_pin_b_oe = ctrl_reg[CTRL_DRIVE];

    // Next values of the two-stage capture
    always_comb begin
        sync1_next = io_pin_b_in;
        sync2_next = sync1_reg;
    end

    // Two-stage capture of the pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence req_s;
        req && !ack_reg;
    endsequence

    sequence write_s;
        avs_write && !avs_waitrequest;
    endsequence

    bus_answer_a: assert property (req_s |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    reset_vals_a: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> low_cfg_reg == RST_LOW_CFG && {2'h0, high_cfg_reg} == RST_HIGH_CFG
        && scratch_reg == RST_SCRATCH && crc_reg == RST_CRC)
        else $error("register reset value wrong");

    scratch_wr_a: assert property (write_s and idx == IDX_SCRATCH
        and avs_byteenable[1:0] == 2'h3 |=> scratch_reg == $past(avs_writedata[15:0]))
        else $error("scratch write lost");

    crc_rd_a: assert property (avs_read && !ack_reg && idx == IDX_CRC
        |=> avs_readdata[15:0] == crc_reg && !avs_waitrequest)
        else $error("crc word read wrong");

    pair_sel_a: assert property (ctrl_reg[CTRL_STATE]
        |-> pwm_bus.high_cnt == high_cfg_reg[HC_MSB:HC_LSB])
        else $error("high state pair not selected");

    high_rsv_a: assert property (avs_read && !ack_reg && idx == IDX_HIGH_CFG
        |=> avs_readdata[15:14] == 2'h0)
        else $error("reserved bits not zero");

    // Steps of a bus transfer
    sequence read_s;
        avs_read && !ack_reg;
    endsequence

    sequence full_wr_s;
        write_s and avs_byteenable[1:0] == 2'h3;
    endsequence

    // Whole-word writes land in the addressed word
    low_wr_a: assert property (full_wr_s and idx == IDX_LOW_CFG
        |=> low_cfg_reg == $past(avs_writedata[15:0]))
        else $error("low pair write lost");

    high_wr_a: assert property (full_wr_s and idx == IDX_HIGH_CFG
        |=> high_cfg_reg == $past(avs_writedata[13:0]))
        else $error("high pair write lost");

    crc_wr_a: assert property (full_wr_s and idx == IDX_CRC
        |=> crc_reg == $past(avs_writedata[15:0]))
        else $error("crc word write lost");

    // Control byte follows a granted write
    ctrl_wr_a: assert property (write_s and idx == IDX_CTRL and avs_byteenable[0]
        |=> ctrl_reg == $past(avs_writedata[1:0]))
        else $error("control write lost");

    // Nothing moves without a granted write
    hold_regs_a: assert property (!wr_go |=> $stable(low_cfg_reg)
        && $stable(high_cfg_reg) && $stable(scratch_reg) && $stable(crc_reg))
        else $error("register changed without a write");

    // Low state takes its own pair
    pair_low_a: assert property (!ctrl_reg[CTRL_STATE]
        |-> pwm_bus.high_cnt == low_cfg_reg[HC_MSB:HC_LSB]
        && pwm_bus.low_cnt == low_cfg_reg[LC_MSB:LC_LSB])
        else $error("low state pair not selected");

    // Unmapped words below the map read as zero
    rd_unmapped_a: assert property (read_s and idx < IDX_LOW_CFG
        |=> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");

    // Status word is read as it stood
    status_rd_a: assert property (read_s and idx == IDX_STATUS
        |=> avs_readdata[15:0] == $past(status_word))
        else $error("status read wrong");

    // Read data stands until the next read
    rd_hold_a: assert property (!(avs_read && !ack_reg) |=> $stable(avs_readdata))
        else $error("read data moved without a read");

    // A request never waits twice
    wait_once_a: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("second wait cycle");

endmodule

`default_nettype wire

// [plp_pkg.sv]
/*
 * Constants, register map and helpers for the pin-level PWM encoder.
 * Assumes a 25 MHz single clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none

package plp_pkg;

    // ****************************************
    // Register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [7:0] IDX_LOW_CFG = 8'h57;
    localparam logic [7:0] IDX_HIGH_CFG = 8'h58;
    localparam logic [7:0] IDX_SCRATCH = 8'h59;
    localparam logic [7:0] IDX_CTRL = 8'h5A;
    localparam logic [7:0] IDX_STATUS = 8'h5B;
    localparam logic [7:0] IDX_CRC = 8'h7E;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [15:0] RST_LOW_CFG = 16'h007F;
    localparam logic [15:0] RST_HIGH_CFG = 16'h3F80;
    localparam logic [15:0] RST_SCRATCH = 16'h5555;
    localparam logic [15:0] RST_CRC = 16'h0000;
    localparam logic [1:0] RST_CTRL = 2'h0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int TB_MSB = 15;
    localparam int TB_LSB = 14;
    localparam int HC_MSB = 13;
    localparam int HC_LSB = 7;
    localparam int LC_MSB = 6;
    localparam int LC_LSB = 0;
    localparam int CTRL_STATE = 0;
    localparam int CTRL_DRIVE = 1;

    // ****************************************
    // Time base lengths in clock cycles
    // ****************************************
    localparam logic [10:0] TB_LEN_0 = 11'h010;
    localparam logic [10:0] TB_LEN_1 = 11'h040;
    localparam logic [10:0] TB_LEN_2 = 11'h100;
    localparam logic [10:0] TB_LEN_3 = 11'h400;

    // Time unit for a selector code
    function automatic logic [10:0] plp_tb_len(input logic [1:0] sel);
        logic [10:0] len;
        unique case (sel)
            2'h0: len = TB_LEN_0;
            2'h1: len = TB_LEN_1;
            2'h2: len = TB_LEN_2;
            2'h3: len = TB_LEN_3;
        endcase
        return len;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] plp_merge16(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

endpackage

`default_nettype wire

// [plp_pwm_if.sv]
/*
 * Carrier between the time base, the phase generator and the top.
 * Assumes all parties share clk.
 */
`timescale 1ns/1ns
`default_nettype none

interface plp_pwm_if;
    logic tick;
    logic [6:0] high_cnt;
    logic [6:0] low_cnt;
    logic level;
    logic in_high;
    modport src (output tick);
    modport gen (input tick, input high_cnt, input low_cnt, output level, output in_high);
endinterface

`default_nettype wire

// [plp_time_base.sv]
/*
 * Time-base divider: one tick every 16, 64, 256 or 1024 cycles.
 * Assumes tb_sel comes from a register on clk.
 */
`timescale 1ns/1ns
`default_nettype none

module plp_time_base
    import plp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] tb_sel,
    plp_pwm_if.src pwm
);

    logic [10:0] div_reg, div_next;

    // Wrap at the selected length
    always_comb begin
        if (div_reg >= plp_tb_len(tb_sel) - 11'h001) begin
            div_next = 11'h000;
        end else begin
            div_next = div_reg + 11'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_reg <= 11'h000;
        end else begin
            div_reg <= div_next;
        end
    end

    assign pwm.tick = (div_reg == 11'h000);

    // Gap between ticks, for checking only
    logic [10:0] gap_reg;
    logic seen_reg, chg_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || pwm.tick) begin
            gap_reg <= 11'h000;
            seen_reg <= !sys_rst;
            chg_reg <= 1'b0;
        end else begin
            gap_reg <= gap_reg + 11'h001;
            chg_reg <= chg_reg || (tb_sel != $past(tb_sel));
        end
    end

    tick_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pwm.tick && seen_reg && !chg_reg && tb_sel == $past(tb_sel))
        |-> gap_reg == plp_tb_len(tb_sel) - 11'h001)
        else $error("tick spacing differs from time base");

endmodule

`default_nettype wire

// [plp_phase_gen.sv]
/*
 * Phase generator: high phase then low phase, counted in ticks.
 * Assumes tick and the count pair arrive on clk from the top.
 */
`timescale 1ns/1ns
`default_nettype none

module plp_phase_gen
    import plp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    plp_pwm_if.gen pwm
);

    typedef enum logic [1:0] {PH_STATIC, PH_HIGH, PH_LOW} plp_phase_e;

    plp_phase_e state_reg, state_next;
    logic [6:0] cnt_reg, cnt_next, hc_reg, hc_next, lc_reg, lc_next;
    logic lvl_reg, lvl_next;
    logic start;

    // Phase sequencing; a new pair is taken only at a cycle boundary
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        hc_next = hc_reg;
        lc_next = lc_reg;
        lvl_next = lvl_reg;
        start = 1'b0;
        if (pwm.tick) begin
            unique case (state_reg)
                PH_HIGH: begin
                    if (cnt_reg == 7'h01) begin
                        state_next = PH_LOW;
                        cnt_next = lc_reg;
                        lvl_next = 1'b0;
                    end else begin
                        cnt_next = cnt_reg - 7'h01;
                    end
                end
                PH_LOW: begin
                    if (cnt_reg == 7'h01) begin
                        start = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - 7'h01;
                    end
                end
                PH_STATIC: start = 1'b1;
                default: state_next = PH_STATIC;
            endcase
        end
        if (start) begin
            hc_next = pwm.high_cnt;
            lc_next = pwm.low_cnt;
            if (pwm.high_cnt == 7'h00) begin
                state_next = PH_STATIC;
                lvl_next = 1'b0;
            end else if (pwm.low_cnt == 7'h00) begin
                state_next = PH_STATIC;
                lvl_next = 1'b1;
            end else begin
                state_next = PH_HIGH;
                cnt_next = pwm.high_cnt;
                lvl_next = 1'b1;
            end
        end
    end

    // Registers, idle after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= PH_STATIC;
            cnt_reg <= 7'h00;
            hc_reg <= 7'h00;
            lc_reg <= 7'h00;
            lvl_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            hc_reg <= hc_next;
            lc_reg <= lc_next;
            lvl_reg <= lvl_next;
        end
    end

    assign pwm.level = lvl_reg;
    assign pwm.in_high = (state_reg == PH_HIGH);

    // Ticks spent in the present phase, for checking only
    logic [7:0] ph_ticks_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || state_next != state_reg) begin
            ph_ticks_reg <= 8'h00;
        end else if (pwm.tick) begin
            ph_ticks_reg <= ph_ticks_reg + 8'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence edge_s;
        pwm.tick && (state_reg == PH_STATIC || (state_reg == PH_LOW && cnt_reg == 7'h01));
    endsequence

    sequence hi_end_s;
        pwm.tick && state_reg == PH_HIGH && cnt_reg == 7'h01;
    endsequence

    sequence lo_end_s;
        pwm.tick && state_reg == PH_LOW && cnt_reg == 7'h01;
    endsequence

    static_low_a: assert property (edge_s and pwm.high_cnt == 7'h00
        |=> !pwm.level && state_reg == PH_STATIC)
        else $error("zero high count not static low");

    static_high_a: assert property (edge_s and pwm.high_cnt != 7'h00
        and pwm.low_cnt == 7'h00 |=> pwm.level && state_reg == PH_STATIC)
        else $error("zero low count not static high");

    high_first_a: assert property (edge_s and pwm.high_cnt != 7'h00
        and pwm.low_cnt != 7'h00 |=> pwm.in_high && pwm.level)
        else $error("cycle did not open with high phase");

    high_len_a: assert property (hi_end_s |-> ph_ticks_reg == {1'b0, hc_reg} - 8'h01
        ##1 !pwm.level)
        else $error("high phase length wrong");

    low_len_a: assert property (lo_end_s |-> ph_ticks_reg == {1'b0, lc_reg} - 8'h01)
        else $error("low phase length wrong");

    reset_idle_a: assert property (@(posedge clk) disable iff (1'b0)
        sys_rst |=> state_reg == PH_STATIC && !pwm.level)
        else $error("generator not idle after reset");

endmodule

`default_nettype wire

// [plp_pwm_monitor.sv]
/*
 * Far-side decoder model: measures the high and low phase lengths on the pin.
 * Assumes the pin level is sampled on clk, the device master clock.
 */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Pin phase decoder
// ****************************************
module plp_pwm_monitor (
    input wire logic clk,
    input wire logic pin,
    output logic [31:0] high_len,
    output logic [31:0] low_len,
    output logic [31:0] rises,
    output logic [31:0] run_len
);
    logic last_reg;

    // Start from an idle line
    initial begin
        high_len = 32'h0;
        low_len = 32'h0;
        rises = 32'h0;
        run_len = 32'h0;
        last_reg = 1'b0;
    end

    // Phase length is taken at the edge that closes it
    always @(posedge clk) begin
        if (pin !== last_reg) begin
            if (pin === 1'b1) begin
                low_len <= run_len;
                rises <= rises + 32'h1;
            end else begin
                high_len <= run_len;
            end
            run_len <= 32'h1;
        end else begin
            run_len <= run_len + 32'h1;
        end
        last_reg <= pin;
    end
endmodule

`default_nettype wire

// [testbench.sv]
/*
 * Self-checking bench for the pin-level PWM encoder.
 * Assumes the Avalon slave gives one wait cycle and the pin decoder model.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import plp_pkg::*;

    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk, sys_rst, avs_read, avs_write, idle_reg;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, high_len, low_len, rises, run_len;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, io_pin_b_out, io_pin_b_oe;
    wire pin_wire;
    int fails = 0;
    int compares = 0;

    // Undriven line shows a toggling pattern
    assign pin_wire = io_pin_b_oe ? io_pin_b_out : idle_reg;

    plp_encoder_top DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .io_pin_b_in(pin_wire),
        .io_pin_b_out(io_pin_b_out), .io_pin_b_oe(io_pin_b_oe));

    plp_pwm_monitor decoder (.clk(clk), .pin(pin_wire), .high_len(high_len),
        .low_len(low_len), .rises(rises), .run_len(run_len));

    // Clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) idle_reg <= ~idle_reg;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'h0};
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {16'h0000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            fails++;
            conclude();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 16'h0000, d);
        check(d, exp);
    endtask

    // Waits for k new rising edges on the pin
    task automatic wait_rises(input int k);
        int n;
        logic [31:0] r0;
        n = 0;
        r0 = rises;
        while (rises < r0 + k && n < 10000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 10000) begin
            fails++;
            conclude();
        end
    endtask

    // Writes a register word, waits, expects a steady level
    task automatic static_case(input logic [7:0] idx, input logic [15:0] cfg,
        input logic exp);
        wr(idx, cfg);
        repeat (200) @(posedge clk);
        check({31'h0, io_pin_b_out}, {31'h0, exp});
        check({31'h0, run_len >= 32'h64}, 32'h1);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdchk(IDX_LOW_CFG, 32'h007F);
        rdchk(IDX_HIGH_CFG, 32'h3F80);
        rdchk(IDX_SCRATCH, 32'h5555);
        rdchk(IDX_CRC, 32'h0000);
        check({31'h0, io_pin_b_out}, 32'h0);
        wr(IDX_CTRL, 16'h0003);
        static_case(IDX_SCRATCH, 16'h0F0F, 1'b1);
        rdchk(IDX_STATUS, 32'h0007);
        wr(IDX_CTRL, 16'h0002);
        static_case(IDX_SCRATCH, 16'h5555, 1'b0);
        rdchk(IDX_STATUS, 32'h0000);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(IDX_SCRATCH, 16'hAAAA);
        rdchk(IDX_SCRATCH, 32'hAAAA);
        wr(IDX_CRC, 16'h1234);
        rdchk(IDX_CRC, 32'h1234);
        wr(IDX_HIGH_CFG, 16'hFFFF);
        rdchk(IDX_HIGH_CFG, 32'h3FFF);
        wr(8'h10, 16'hBEEF);
        rdchk(8'h10, 32'h0000);
        $display("test registers done");
    endtask

    task automatic t_timebase();
        logic [31:0] t;
        wr(IDX_CTRL, 16'h0002);
        for (int tb = 0; tb < 4; tb++) begin
            t = 32'h10 << (2 * tb);
            wr(IDX_LOW_CFG, {tb[1:0], 7'h01, 7'h01});
            wait_rises(3);
            check(high_len, t);
            check(low_len, t);
        end
        $display("test time base done");
    endtask

    task automatic t_counts();
        wr(IDX_LOW_CFG, {2'h0, 7'h03, 7'h02});
        wait_rises(3);
        check(high_len, 32'h30);
        check(low_len, 32'h20);
        static_case(IDX_LOW_CFG, {2'h0, 7'h00, 7'h05}, 1'b0);
        static_case(IDX_LOW_CFG, {2'h0, 7'h05, 7'h00}, 1'b1);
        static_case(IDX_LOW_CFG, {2'h0, 7'h00, 7'h00}, 1'b0);
        $display("test counts done");
    endtask

    task automatic t_high_pair();
        wr(IDX_LOW_CFG, {2'h1, 7'h01, 7'h01});
        wr(IDX_HIGH_CFG, {2'h0, 7'h02, 7'h05});
        wr(IDX_CTRL, 16'h0003);
        wait_rises(3);
        check(high_len, 32'h80);
        check(low_len, 32'h140);
        $display("test high pair done");
    endtask

    task automatic t_mid_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        check({30'h0, io_pin_b_oe, io_pin_b_out}, 32'h0);
        rdchk(IDX_HIGH_CFG, 32'h3F80);
        rdchk(IDX_LOW_CFG, 32'h007F);
        $display("test mid reset done");
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        sys_rst = 1'b1;
        idle_reg = 1'b0;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_timebase();
        t_counts();
        t_high_pair();
        t_mid_reset();
        conclude();
    end
endmodule

`default_nettype wire
